// file: include/dtc_pkg.sv
// constants, types and count function for the dual timer block
package dtc_pkg;

  localparam logic [7:0] DTC_ADDR_CONTROL = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE    = 8'h89;
  localparam logic [7:0] DTC_ADDR_TL0     = 8'h8A;
  localparam logic [7:0] DTC_ADDR_TL1     = 8'h8B;
  localparam logic [7:0] DTC_ADDR_TH0     = 8'h8C;
  localparam logic [7:0] DTC_ADDR_TH1     = 8'h8D;
  localparam logic [7:0] DTC_RESET_VALUE  = 8'h00;
  localparam logic [7:0] DTC_UNMAPPED     = 8'h00;

  // timer01_control fields
  localparam int DTC_TF1 = 7;
  localparam int DTC_TR1 = 6;
  localparam int DTC_TF0 = 5;
  localparam int DTC_TR0 = 4;
  localparam int DTC_IE1 = 3;
  localparam int DTC_IT1 = 2;
  localparam int DTC_IE0 = 1;
  localparam int DTC_IT0 = 0;

  // timer01_mode fields
  localparam int DTC_TIMER1_PIN_GATING  = 7;
  localparam int DTC_CT1    = 6;
  localparam int DTC_M1_LSB = 4;
  localparam int DTC_TIMER0_PIN_GATING  = 3;
  localparam int DTC_CT0    = 2;
  localparam int DTC_M0_LSB = 0;

  // prescaler divisors
  localparam logic [5:0] DTC_DIV12   = 6'h0C;
  localparam logic [5:0] DTC_DIV4    = 6'h04;
  localparam logic [5:0] DTC_DIV48   = 6'h30;
  localparam logic [5:0] DTC_EXT_DIV = 6'h08;

  // synchroniser lanes
  localparam int DTC_SYNC_W = 5;
  localparam int DTC_S_IRQ0 = 0;
  localparam int DTC_S_IRQ1 = 1;
  localparam int DTC_S_CNT0 = 2;
  localparam int DTC_S_CNT1 = 3;
  localparam int DTC_S_EXTC = 4;

  typedef enum logic [1:0]
  {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD8,
    DTC_MODE_SPLIT
  } dtc_mode_type;

  typedef struct packed
  {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } dtc_count_type;

  // one increment of a timer in the given mode
  function automatic dtc_count_type dtc_count(
    input dtc_mode_type m,
    input logic [7:0]   lo,
    input logic [7:0]   hi
  );
    dtc_count_type r;
    r = '{lo: lo, hi: hi, ovf: 1'b0};
    case (m)
      DTC_MODE_13BIT:
      begin
        r.lo[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == 5'h1F)
        begin
          r.hi  = hi + 8'h01;
          r.ovf = (hi == 8'hFF);
        end
      end
      DTC_MODE_16BIT:
      begin
        {r.hi, r.lo} = {hi, lo} + 16'h0001;
        r.ovf        = ({hi, lo} == 16'hFFFF);
      end
      DTC_MODE_RELOAD8:
      begin
        r.lo  = (lo == 8'hFF) ? hi : lo + 8'h01;
        r.ovf = (lo == 8'hFF);
      end
      default:
      begin
        r.lo  = lo + 8'h01;
        r.ovf = (lo == 8'hFF);
      end
    endcase
    return r;
  endfunction

endpackage

// file: rtl/dtc_prescaler.sv
// shared prescaler for the timer clock ticks
`timescale 1ns/1ns
`default_nettype none
module dtc_prescaler
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] divider_sel,
  input  wire logic       ext_clk_level,
  output logic            tick
);
  import dtc_pkg::*;

  typedef struct packed
  {
    logic [5:0] cnt;
    logic       ext_prev;
  } dtc_pre_state_type;

  dtc_pre_state_type s;
  dtc_pre_state_type next_s;
  logic [5:0]        limit;
  logic              ext_rise;

  always_comb
  begin
    next_s     = s;
    tick       = 1'b0;
    limit      = DTC_DIV12;
    ext_rise   = ext_clk_level & ~s.ext_prev;
    next_s.ext_prev = ext_clk_level;
    case (divider_sel)
      2'h0: limit = DTC_DIV12;
      2'h1: limit = DTC_DIV4;
      2'h2: limit = DTC_DIV48;
      default: limit = DTC_EXT_DIV;
    endcase
    if (divider_sel == 2'h3)
    begin
      // external clock, already synchronised, divided by eight
      if (ext_rise)
      begin
        tick       = (s.cnt >= limit - 6'h01);
        next_s.cnt = tick ? 6'h00 : s.cnt + 6'h01;
      end
    end
    else
    begin
      tick       = (s.cnt >= limit - 6'h01);
      next_s.cnt = tick ? 6'h00 : s.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  tick_spacing_a: assert property (@(posedge clk) disable iff (!resetn)
    (tick && divider_sel == 2'h1) ##1 (divider_sel == 2'h1)[*3] |->
    ##1 tick) else $error("prescaler divide by four broken");

endmodule // dtc_prescaler
`default_nettype wire

// file: rtl/dtc_timers.sv
// timer 0/1 counters with external interrupt flags, special register port
// Operation
// - rollover sets overflow flag (not timer1 while timer0 in mode 3); vector ack clears
// - timer counts only while run bit set; timer1 ignores it while timer0 in mode 3
// - external flag set on selected edge/level
// - edge mode flag cleared on vector ack
// - type bit 0 level, 1 edge; polarity input
// - gate bit adds active irq pin condition
// - counter select counts count pin falling edges
// - timer select counts chosen internal clock
// - modes 13-bit, 16-bit, reload, timer1 inactive
// - timer0 mode 3 splits into two bytes
// - low/high bytes readable, writable, reset zero
// - clock select 1 system clock, 0 prescaled
// - prescaler divides 12, 4, 48, ext/8
`timescale 1ns/1ns
`default_nettype none
module dtc_timers
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer0_vector_ack,
  input  wire logic       timer1_vector_ack,
  input  wire logic       ext_irq0_vector_ack,
  input  wire logic       ext_irq1_vector_ack,
  input  wire logic       timer0_clock_sel,
  input  wire logic       timer1_clock_sel,
  input  wire logic [1:0] shared_clock_divider_sel,
  input  wire logic       ext_irq0_polarity,
  input  wire logic       ext_irq1_polarity,
  input  wire logic       ext_irq0_pin,
  input  wire logic       ext_irq1_pin,
  input  wire logic       timer0_count_pin,
  input  wire logic       timer1_count_pin,
  input  wire logic       ext_clk_pin,
  output logic            timer0_overflow_flag,
  output logic            timer1_overflow_flag,
  output logic            ext_irq0_flag,
  output logic            ext_irq1_flag
);
  import dtc_pkg::*;

  typedef struct packed
  {
    logic [7:0]            control;
    logic [7:0]            mode;
    logic [7:0]            tl0;
    logic [7:0]            tl1;
    logic [7:0]            th0;
    logic [7:0]            th1;
    logic [7:0]            rdata;
    logic [DTC_SYNC_W-1:0] sync1;
    logic [DTC_SYNC_W-1:0] sync2;
    logic [DTC_SYNC_W-1:0] prev;
  } dtc_state_type;

  dtc_state_type s;
  dtc_state_type next_s;
  dtc_mode_type  mode0;
  dtc_mode_type  mode1;
  dtc_count_type c0;
  dtc_count_type c1;
  logic          pre_tick;
  logic          act0;
  logic          act1;
  logic          fall0;
  logic          fall1;
  logic          tick0;
  logic          tick1;
  logic          tmr_tick0;
  logic          inc0;
  logic          inc1;
  logic          inc0_hi;
  logic          split0;
  logic          set_tf0;
  logic          set_tf1;
  logic          set_ie0;
  logic          set_ie1;
  logic          wr_ctl;

  dtc_prescaler u_prescaler
  (
    .clk           (clk),
    .resetn        (resetn),
    .divider_sel   (shared_clock_divider_sel),
    .ext_clk_level (s.sync2[DTC_S_EXTC]),
    .tick          (pre_tick)
  );

  // irq pin active level per polarity setting
  assign act0  = (s.sync2[DTC_S_IRQ0] == ext_irq0_polarity);
  assign act1  = (s.sync2[DTC_S_IRQ1] == ext_irq1_polarity);
  assign fall0 = s.prev[DTC_S_CNT0] & ~s.sync2[DTC_S_CNT0];
  assign fall1 = s.prev[DTC_S_CNT1] & ~s.sync2[DTC_S_CNT1];
  assign mode0 = dtc_mode_type'(s.mode[DTC_M0_LSB +: 2]);
  assign mode1 = dtc_mode_type'(s.mode[DTC_M1_LSB +: 2]);
  assign split0 = (mode0 == DTC_MODE_SPLIT);

  // clock source choice
  assign tmr_tick0 = timer0_clock_sel ? 1'b1 : pre_tick;
  assign tick0 = s.mode[DTC_CT0] ? fall0 : tmr_tick0;
  assign tick1 = s.mode[DTC_CT1] ? fall1
               : (timer1_clock_sel ? 1'b1 : pre_tick);

  // run and gating
  assign inc0 = tick0 & s.control[DTC_TR0]
              & (~s.mode[DTC_TIMER0_PIN_GATING] | act0);
  assign inc1 = tick1 & (s.control[DTC_TR1] | split0)
              & (~s.mode[DTC_TIMER1_PIN_GATING] | act1)
              & (mode1 != DTC_MODE_SPLIT);
  // high byte of timer0 in split mode borrows timer1 run bit
  assign inc0_hi = split0 & tmr_tick0 & s.control[DTC_TR1];

  assign c0 = dtc_count(mode0, s.tl0, s.th0);
  assign c1 = dtc_count(mode1, s.tl1, s.th1);

  assign set_tf0 = inc0 & c0.ovf;
  assign set_tf1 = (inc1 & c1.ovf & ~split0)
                 | (inc0_hi & (s.th0 == 8'hFF));
  assign set_ie0 = s.control[DTC_IT0]
                 ? (act0 & ~(s.prev[DTC_S_IRQ0] == ext_irq0_polarity))
                 : act0;
  assign set_ie1 = s.control[DTC_IT1]
                 ? (act1 & ~(s.prev[DTC_S_IRQ1] == ext_irq1_polarity))
                 : act1;
  assign wr_ctl  = sfr_wr & (sfr_addr == DTC_ADDR_CONTROL);

  always_comb
  begin
    next_s       = s;
    next_s.sync1 = {ext_clk_pin, timer1_count_pin, timer0_count_pin,
                    ext_irq1_pin, ext_irq0_pin};
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    // counting
    if (inc0)
    begin
      next_s.tl0 = c0.lo;
      if (!split0)
        next_s.th0 = c0.hi;
    end
    if (inc0_hi)
      next_s.th0 = s.th0 + 8'h01;
    if (inc1)
    begin
      next_s.tl1 = c1.lo;
      next_s.th1 = c1.hi;
    end
    // software writes override counting
    if (sfr_wr)
    begin
      case (sfr_addr)
        DTC_ADDR_CONTROL: next_s.control = sfr_wdata;
        DTC_ADDR_MODE:    next_s.mode    = sfr_wdata;
        DTC_ADDR_TL0:     next_s.tl0     = sfr_wdata;
        DTC_ADDR_TL1:     next_s.tl1     = sfr_wdata;
        DTC_ADDR_TH0:     next_s.th0     = sfr_wdata;
        DTC_ADDR_TH1:     next_s.th1     = sfr_wdata;
        default:          next_s.mode    = next_s.mode;
      endcase
    end
    // vector acknowledge clears
    if (timer0_vector_ack)
      next_s.control[DTC_TF0] = 1'b0;
    if (timer1_vector_ack)
      next_s.control[DTC_TF1] = 1'b0;
    if (ext_irq0_vector_ack && s.control[DTC_IT0])
      next_s.control[DTC_IE0] = 1'b0;
    if (ext_irq1_vector_ack && s.control[DTC_IT1])
      next_s.control[DTC_IE1] = 1'b0;
    // hardware sets win over any clear
    if (set_tf0)
      next_s.control[DTC_TF0] = 1'b1;
    if (set_tf1)
      next_s.control[DTC_TF1] = 1'b1;
    if (set_ie0)
      next_s.control[DTC_IE0] = 1'b1;
    if (set_ie1)
      next_s.control[DTC_IE1] = 1'b1;
    // read data
    if (sfr_rd)
    begin
      case (sfr_addr)
        DTC_ADDR_CONTROL: next_s.rdata = s.control;
        DTC_ADDR_MODE:    next_s.rdata = s.mode;
        DTC_ADDR_TL0:     next_s.rdata = s.tl0;
        DTC_ADDR_TL1:     next_s.rdata = s.tl1;
        DTC_ADDR_TH0:     next_s.rdata = s.th0;
        DTC_ADDR_TH1:     next_s.rdata = s.th1;
        default:          next_s.rdata = DTC_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign sfr_rdata            = s.rdata;
  assign timer0_overflow_flag = s.control[DTC_TF0];
  assign timer1_overflow_flag = s.control[DTC_TF1];
  assign ext_irq0_flag        = s.control[DTC_IE0];
  assign ext_irq1_flag        = s.control[DTC_IE1];

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  tf0_rollover_a: assert property (set_tf0 |=> timer0_overflow_flag)
    else $error("timer0 flag not set on rollover");
  tf0_ack_clear_a: assert property (
    (timer0_vector_ack && !set_tf0 && !wr_ctl) |=> !timer0_overflow_flag)
    else $error("timer0 flag not cleared by vector");
  tf1_ack_clear_a: assert property (
    (timer1_vector_ack && !set_tf1 && !wr_ctl) |=> !timer1_overflow_flag)
    else $error("timer1 flag not cleared by vector");
  ie0_ack_clear_a: assert property (
    (ext_irq0_vector_ack && s.control[DTC_IT0] && !set_ie0 && !wr_ctl)
    |=> !ext_irq0_flag)
    else $error("irq0 edge flag not cleared by vector");
  gate_pass_a: assert property (
    (s.mode[DTC_TIMER0_PIN_GATING] && act0 && s.control[DTC_TR0] && tick0
     && mode0 == DTC_MODE_16BIT && s.tl0 != 8'hFF && !sfr_wr)
    |=> s.tl0 == $past(s.tl0) + 8'h01)
    else $error("gated timer stalled with pin active");
  run_hold_a: assert property (
    (!s.control[DTC_TR0] && !sfr_wr) |=> $stable(s.tl0))
    else $error("timer0 counted while stopped");
  ext_edge_set_a: assert property (
    (s.control[DTC_IT0] && act0
     && s.prev[DTC_S_IRQ0] != ext_irq0_polarity) |=> ext_irq0_flag)
    else $error("edge not flagged");
  level_keep_a: assert property (
    (!s.control[DTC_IT0] && act0) |=> ext_irq0_flag)
    else $error("level flag dropped while active");
  ext_ack_a: assert property (
    (ext_irq1_vector_ack && s.control[DTC_IT1] && !set_ie1 && !wr_ctl)
    |=> !ext_irq1_flag)
    else $error("edge flag not cleared by vector");
  gate_block_a: assert property (
    (s.mode[DTC_TIMER0_PIN_GATING] && !act0 && !sfr_wr) |=> $stable(s.tl0))
    else $error("gated timer counted");
  cnt_pin_a: assert property (
    (s.mode[DTC_CT0] && s.control[DTC_TR0] && !s.mode[DTC_TIMER0_PIN_GATING]
     && mode0 == DTC_MODE_16BIT && fall0 && !sfr_wr)
    |=> s.tl0 == $past(s.tl0) + 8'h01)
    else $error("count pin edge missed");
  sysclk_run_a: assert property (
    (!s.mode[DTC_CT1] && timer1_clock_sel && s.control[DTC_TR1]
     && !s.mode[DTC_TIMER1_PIN_GATING] && mode1 == DTC_MODE_16BIT && !sfr_wr)
    |=> s.tl1 == $past(s.tl1) + 8'h01)
    else $error("timer1 not counting system clock");
  t1_idle_a: assert property (
    (mode1 == DTC_MODE_SPLIT && !sfr_wr) |=> $stable({s.th1, s.tl1}))
    else $error("timer1 ran in inactive mode");
  split_hi_a: assert property (
    (inc0_hi && s.th0 == 8'hFF) |=> timer1_overflow_flag)
    else $error("split high byte overflow lost");
  reload_a: assert property (
    (inc0 && mode0 == DTC_MODE_RELOAD8 && s.tl0 == 8'hFF && !sfr_wr)
    |=> (s.tl0 == s.th0 && timer0_overflow_flag))
    else $error("auto reload wrong");
  carry13_a: assert property (
    (inc1 && mode1 == DTC_MODE_13BIT && s.tl1[4:0] == 5'h1F && !sfr_wr)
    |=> (s.th1 == $past(s.th1) + 8'h01 && s.tl1[4:0] == 5'h00))
    else $error("13-bit carry wrong");
  write_read_a: assert property (
    (sfr_wr && sfr_addr == DTC_ADDR_TH1 && mode1 == DTC_MODE_SPLIT)
    ##1 (sfr_rd && sfr_addr == DTC_ADDR_TH1 && !sfr_wr)
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("high byte readback wrong");

  rollover_c: cover property (set_tf0 ##1 timer0_vector_ack);
  split_c:    cover property (inc0_hi && s.th0 == 8'hFF);
  edge_c:     cover property (set_ie1 && s.control[DTC_IT1]);
  reload_c:   cover property (inc0 && mode0 == DTC_MODE_RELOAD8 && c0.ovf);
  gate_c:     cover property (inc0 && s.mode[DTC_TIMER0_PIN_GATING]);

endmodule // dtc_timers
`default_nettype wire

// file: tb/dtc_cpu_model.sv
// cpu core model that vectors to enabled interrupt flags
`timescale 1ns/1ns
`default_nettype none
module dtc_cpu_model
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [3:0] irq_en,
  input  wire logic [1:0] dly,
  input  wire logic [3:0] flags,
  output logic      [3:0] acks
);
  logic [3:0] req_q;
  logic [3:0] pend;
  logic [1:0] wait_cnt;
  // a newly raised enabled flag is vectored dly+1 cycles after it is first sampled
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_q    <= 4'h0;
      pend     <= 4'h0;
      wait_cnt <= 2'h0;
      acks     <= 4'h0;
    end
    else
    begin
      acks  <= 4'h0;
      req_q <= irq_en & flags;
      pend  <= pend | (irq_en & flags & ~req_q);
      if (pend != 4'h0)
      begin
        if (wait_cnt == dly)
        begin
          acks     <= pend;
          pend     <= 4'h0;
          wait_cnt <= 2'h0;
        end
        else
          wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule // dtc_cpu_model
`default_nettype wire

// file: tb/dtc_timers_tb.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ns
`default_nettype none
module dtc_timers_tb;
  import dtc_pkg::*;
  logic       clk, resetn, wr, rd, tg;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] acks, flags, irq_en;
  logic [1:0] dly, dsel;
  logic       csel0, csel1, pol0, pol1;
  logic       irq0, irq1, cnt0, cnt1, extc;
  int         bad_count, n_tests;
  logic [7:0] exp_pre [4] = '{8'h08, 8'h18, 8'h02, 8'h03};

  dtc_timers DUT
  (
    .clk(clk), .resetn(resetn), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .timer0_vector_ack(acks[0]), .timer1_vector_ack(acks[1]),
    .ext_irq0_vector_ack(acks[2]), .ext_irq1_vector_ack(acks[3]),
    .timer0_clock_sel(csel0), .timer1_clock_sel(csel1),
    .shared_clock_divider_sel(dsel),
    .ext_irq0_polarity(pol0), .ext_irq1_polarity(pol1),
    .ext_irq0_pin(irq0), .ext_irq1_pin(irq1),
    .timer0_count_pin(cnt0), .timer1_count_pin(cnt1),
    .ext_clk_pin(extc),
    .timer0_overflow_flag(flags[0]), .timer1_overflow_flag(flags[1]),
    .ext_irq0_flag(flags[2]), .ext_irq1_flag(flags[3])
  );

  dtc_cpu_model cpu
  (
    .clk(clk), .resetn(resetn), .irq_en(irq_en), .dly(dly),
    .flags(flags), .acks(acks)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // external prescaler clock, period four system clocks
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      tg   <= 1'b0;
      extc <= 1'b0;
    end
    else
    begin
      tg <= ~tg;
      if (tg)
        extc <= ~extc;
    end
  end

  task automatic test_done;
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input logic got, exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdata, exp);
  endtask

  task automatic load(input logic [7:0] md, la, l, ha, h);
    wr_reg(DTC_ADDR_MODE, md);
    wr_reg(la, l);
    wr_reg(ha, h);
  endtask

  // counts on k+2 edges between the two control writes
  task automatic run(input logic [7:0] on, off, input int k);
    wr_reg(DTC_ADDR_CONTROL, on);
    repeat (k) @(posedge clk);
    wr_reg(DTC_ADDR_CONTROL, off);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done;
  end

  initial
  begin
    {resetn, wr, rd, irq0, irq1} = 5'h00;
    {addr, wdata, irq_en, dly, dsel} = 24'h000000;
    {csel0, csel1, pol0, pol1, cnt0, cnt1} = 6'h3F;
    bad_count = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk({4'h0, flags}, DTC_RESET_VALUE);
    for (int a = 8'h88; a <= 8'h8E; a++)
      rd_reg(8'(a), DTC_RESET_VALUE);
    for (int a = 8'h89; a <= 8'h8D; a++)
      wr_reg(8'(a), 8'(a) ^ 8'h5A);
    for (int a = 8'h89; a <= 8'h8D; a++)
      rd_reg(8'(a), 8'(a) ^ 8'h5A);
    // 16-bit rollover, set beats the clear written with the stop
    load(8'h01, DTC_ADDR_TL0, 8'hFE, DTC_ADDR_TH0, 8'hFF);
    run(8'h10, 8'h00, 0);
    chkf(flags[0], 1'b1);
    rd_reg(DTC_ADDR_TL0, 8'h00);
    rd_reg(DTC_ADDR_TH0, 8'h00);
    irq_en <= 4'h1;
    repeat (8) @(posedge clk);
    chkf(flags[0], 1'b0);
    irq_en <= 4'h0;
    load(8'h00, DTC_ADDR_TL0, 8'hFF, DTC_ADDR_TH0, 8'h12);
    run(8'h10, 8'h00, 0);
    rd_reg(DTC_ADDR_TL0, 8'hE1);
    rd_reg(DTC_ADDR_TH0, 8'h13);
    load(8'h02, DTC_ADDR_TL0, 8'hFF, DTC_ADDR_TH0, 8'h80);
    run(8'h10, 8'h00, 0);
    rd_reg(DTC_ADDR_TL0, 8'h81);
    rd_reg(DTC_ADDR_TH0, 8'h80);
    chkf(flags[0], 1'b0);
    load(8'h03, DTC_ADDR_TL0, 8'hFE, DTC_ADDR_TH0, 8'hFF);
    run(8'h50, 8'h00, 0);
    rd_reg(DTC_ADDR_TL0, 8'h00);
    rd_reg(DTC_ADDR_TH0, 8'h01);
    chkf(flags[0], 1'b1);
    chkf(flags[1], 1'b0);
    wr_reg(DTC_ADDR_CONTROL, 8'h00);
    load(8'h30, DTC_ADDR_TL1, 8'h00, DTC_ADDR_TH1, 8'h00);
    run(8'h40, 8'h00, 5);
    rd_reg(DTC_ADDR_TL1, 8'h00);
    load(8'h10, DTC_ADDR_TL1, 8'h10, DTC_ADDR_TH1, 8'h00);
    run(8'h40, 8'h00, 3);
    repeat (5) @(posedge clk);
    rd_reg(DTC_ADDR_TL1, 8'h15);
    // counter mode, three falling edges on the count pin
    load(8'h05, DTC_ADDR_TL0, 8'h00, DTC_ADDR_TH0, 8'h00);
    wr_reg(DTC_ADDR_CONTROL, 8'h10);
    repeat (3)
    begin
      cnt0 <= 1'b0;
      repeat (4) @(posedge clk);
      cnt0 <= 1'b1;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    wr_reg(DTC_ADDR_CONTROL, 8'h00);
    rd_reg(DTC_ADDR_TL0, 8'h03);
    load(8'h09, DTC_ADDR_TL0, 8'h00, DTC_ADDR_TH0, 8'h00);
    run(8'h10, 8'h00, 5);
    rd_reg(DTC_ADDR_TL0, 8'h00);
    // gated timer with its irq pin active counts normally
    irq0 <= 1'b1;
    repeat (4) @(posedge clk);
    run(8'h10, 8'h00, 5);
    rd_reg(DTC_ADDR_TL0, 8'h07);
    irq0 <= 1'b0;
    repeat (4) @(posedge clk);
    // prescaled clock, 96 edge window per divider
    csel0 <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      dsel <= 2'(i);
      load(8'h01, DTC_ADDR_TL0, 8'h00, DTC_ADDR_TH0, 8'h00);
      repeat (200) @(posedge clk);
      run(8'h10, 8'h00, 94);
      rd_reg(DTC_ADDR_TL0, exp_pre[i]);
    end
    csel0 <= 1'b1;
    // external interrupt 1, edge then level
    wr_reg(DTC_ADDR_CONTROL, 8'h04);
    irq1 <= 1'b1;
    repeat (5) @(posedge clk);
    chkf(flags[3], 1'b1);
    dly <= 2'h3;
    irq_en <= 4'h8;
    repeat (10) @(posedge clk);
    chkf(flags[3], 1'b0);
    irq1 <= 1'b0;
    wr_reg(DTC_ADDR_CONTROL, 8'h00);
    irq1 <= 1'b1;
    repeat (5) @(posedge clk);
    chkf(flags[3], 1'b1);
    repeat (10) @(posedge clk);
    chkf(flags[3], 1'b1);
    irq1 <= 1'b0;
    repeat (5) @(posedge clk);
    wr_reg(DTC_ADDR_CONTROL, 8'h00);
    chkf(flags[3], 1'b0);
    // external interrupt 0, active low edge
    irq0 <= 1'b1;
    pol0 <= 1'b0;
    dly <= 2'h0;
    irq_en <= 4'h0;
    repeat (5) @(posedge clk);
    wr_reg(DTC_ADDR_CONTROL, 8'h01);
    irq0 <= 1'b0;
    repeat (5) @(posedge clk);
    chkf(flags[2], 1'b1);
    irq_en <= 4'h4;
    repeat (10) @(posedge clk);
    chkf(flags[2], 1'b0);
    test_done;
  end
endmodule // dtc_timers_tb
`default_nettype wire
